// ===== pkg/cpm_pkg.sv
// Package for the programmer-model register file with alternate contexts
package cpm_pkg;
  // ----------------------------------------
  // Geometry
  // ----------------------------------------
  localparam int unsigned WREG_W      = 16;
  localparam int unsigned NUM_WREG    = 16;
  localparam int unsigned NUM_CTX     = 5;
  localparam int unsigned CTX_W       = 3;
  localparam int unsigned ACC_W       = 40;
  localparam int unsigned PC_W        = 23;
  localparam int unsigned INSN_W      = 24;
  localparam int unsigned DADDR_W     = 16;
  localparam int unsigned PSV_PAGE_W  = 8;
  // ----------------------------------------
  // APB register map (byte offsets)
  // ----------------------------------------
  localparam logic [11:0] WREG_BASE    = 12'h000;
  localparam logic [11:0] ACCUMULATOR_A_LO      = 12'h040;
  localparam logic [11:0] ACCUMULATOR_A_HI      = 12'h044;
  localparam logic [11:0] ACCUMULATOR_B_LO      = 12'h048;
  localparam logic [11:0] ACCUMULATOR_B_HI      = 12'h04c;
  localparam logic [11:0] PC_OFF       = 12'h050;
  localparam logic [11:0] LSTART_L     = 12'h054;
  localparam logic [11:0] LSTART_H     = 12'h058;
  localparam logic [11:0] ALTCFG_OFF   = 12'h05c;
  localparam logic [11:0] CTXSTAT_OFF  = 12'h060;
  localparam logic [11:0] CTXSWP_OFF   = 12'h064;
  localparam logic [11:0] AGCFG_OFF    = 12'h068;
  localparam logic [11:0] XMOD_START   = 12'h06c;
  localparam logic [11:0] XMOD_END     = 12'h070;
  localparam logic [11:0] YMOD_START   = 12'h074;
  localparam logic [11:0] YMOD_END     = 12'h078;
  localparam logic [11:0] BREV_OFF     = 12'h07c;
  localparam logic [11:0] AGREQ_OFF    = 12'h080;
  localparam logic [11:0] AGRES_OFF    = 12'h084;
  // ----------------------------------------
  // Field positions and reset values
  // ----------------------------------------
  localparam int unsigned CCTX_LSB     = 0;
  localparam int unsigned MCTX_LSB     = 8;
  localparam int unsigned AG_XMOD_BIT  = 0;
  localparam int unsigned AG_YMOD_BIT  = 1;
  localparam int unsigned AG_BREV_BIT  = 2;
  localparam int unsigned AG_PSV_BIT   = 3;
  localparam int unsigned AG_PAGE_LSB  = 8;
  localparam logic [31:0] ALTCFG_RST   = 32'h0000_0000;
  localparam logic [15:0] SP_RST       = 16'h1000;
  localparam logic [15:0] XY_SPLIT_DEF = 16'h0800;
  localparam logic [15:0] PSV_WIN_BASE = 16'h8000;
  localparam int unsigned PENDING_CYC  = 2;

  typedef logic [WREG_W-1:0] cpm_word_t;
  typedef logic [CTX_W-1:0]  cpm_ctx_t;

  // Operation from the execution unit
  typedef enum logic [1:0] {CPM_OP_NONE, CPM_OP_SWAP, CPM_OP_IRQ, CPM_OP_RETI} cpm_op_t;

  typedef struct packed {
    cpm_op_t              op;
    logic [CTX_W-1:0]     arg;
    logic                 wr_en;
    logic [3:0]           wr_idx;
    cpm_word_t            wr_data;
  } cpm_exec_t;

  typedef struct packed {
    logic                 dual;
    logic                 xmod;
    logic                 brev;
    cpm_word_t            xaddr;
    cpm_word_t            yaddr;
  } cpm_agreq_t;
endpackage : cpm_pkg

// ===== hdl/cpm_regfile.sv
// Programmer-model register file with alternate contexts and address generators
`timescale 1ns/100ps
// Overview of operation
// - Sixteen 16-bit general working registers
// - Last working register is stack pointer
// - Four alternate contexts, registers 0-14 only
// - 3-bit field binds context to priority
// - Swap instruction selects context manually
// - Status shows current and manual context
// - Mapped registers reach active context copy
// - 23-bit program counter, 4M words
// - 24-bit instructions, variable opcode length
// - Two 40-bit accumulators, four alternate sets
// - 4K-word data space split X/Y
// - General instructions use X generator linearly
// - Dual-operand reads use X and Y
// - Upper 32 KB windows program space
// - Modulo addressing in X and Y
// - Bit-reversed addressing on X only
// - Most instructions single-cycle, some longer
// - Hardware loops interruptible anywhere
// - Loop start halves read-only
// - All model registers memory-mapped
// - At most six addressing modes per group
module cpm_regfile
  import cpm_pkg::*;
#(
  parameter int unsigned XY_SPLIT = 16'h0800
) (
  input  wire logic                 pclk,
  input  wire logic                 presetn,
  input  wire logic                 clk_en,
  input  wire logic                 psel,
  input  wire logic                 penable,
  input  wire logic                 pwrite,
  input  wire logic [11:0]          paddr,
  input  wire logic [31:0]          pwdata,
  input  wire logic [3:0]           pstrb,
  output logic      [31:0]          prdata,
  output logic                      pready,
  output logic                      pslverr,
  input  wire cpm_pkg::cpm_exec_t   exec_in,
  input  wire logic                 pc_load,
  input  wire logic [cpm_pkg::PC_W-1:0] pc_target,
  input  wire logic                 pc_step,
  input  wire logic [cpm_pkg::INSN_W-1:0] insn_word,
  input  wire logic                 loop_start_load,
  output logic [cpm_pkg::PC_W-1:0]  pc_out,
  output logic                      pmem_valid,
  output logic                      busy_out,
  output logic [3:0]                insn_group_out,
  output cpm_pkg::cpm_ctx_t         current_context_index,
  output cpm_pkg::cpm_word_t        stack_pointer_register,
  output logic [cpm_pkg::PC_W-1:0]  pmem_addr_out,
  output logic                      ag_done
);
  import cpm_pkg::*;

  initial begin
    if (XY_SPLIT == 0 || XY_SPLIT > 16'h1000) $error("XY_SPLIT outside 4K words");
  end

  // ----------------------------------------
  // Storage
  // ----------------------------------------
  cpm_word_t            wreg_ff [NUM_CTX][NUM_WREG-1];
  cpm_word_t            sp_ff;
  logic [ACC_W-1:0]     accumulator_a_ff [NUM_CTX];
  logic [ACC_W-1:0]     accumulator_b_ff [NUM_CTX];
  logic [PC_W-1:0]      pc_ff;
  logic [PC_W-1:0]      lstart_ff;
  logic [31:0]          alt_register_config_word;
  cpm_ctx_t             cctx_ff;
  cpm_ctx_t             mctx_ff;
  cpm_ctx_t             ret_ctx_ff [8];
  logic [2:0]           nest_ff;
  logic [31:0]          agcfg_ff;
  cpm_word_t            xms_ff, xme_ff, yms_ff, yme_ff, brev_ff;
  cpm_word_t            xres_ff, yres_ff;
  logic [1:0]           wait_ff;
  logic [3:0]           group_ff;

  logic                 wr_acc, rd_acc;
  assign wr_acc = psel && penable && pwrite && clk_en;
  assign rd_acc = psel && penable && !pwrite;
  assign pready = 1'b1;

  // ----------------------------------------
  // Address decode
  // ----------------------------------------
  logic       hit_wreg;
  logic [3:0] widx;
  logic       known;
  assign hit_wreg = (paddr[11:6] == WREG_BASE[11:6]) && (paddr[1:0] == 2'b00);
  assign widx     = paddr[5:2];

  always_comb begin
    unique case (paddr)
      ACCUMULATOR_A_LO, ACCUMULATOR_A_HI, ACCUMULATOR_B_LO, ACCUMULATOR_B_HI, PC_OFF, LSTART_L, LSTART_H,
      ALTCFG_OFF, CTXSTAT_OFF, CTXSWP_OFF, AGCFG_OFF, XMOD_START, XMOD_END,
      YMOD_START, YMOD_END, BREV_OFF, AGREQ_OFF, AGRES_OFF: known = 1'b1;
      default: known = hit_wreg;
    endcase
  end

  // Read-only halves refuse writes with an error
  assign pslverr = psel && penable && (!known ||
                   (pwrite && (paddr == LSTART_L || paddr == LSTART_H)));

  // Byte-lane merge of a 32-bit word
  function automatic logic [31:0] merge(input logic [31:0] old, input logic [31:0] nw,
                                        input logic [3:0] st);
    logic [31:0] r;
    r = old;
    for (int i = 0; i < 4; i++) begin
      if (st[i]) r[i*8 +: 8] = nw[i*8 +: 8];
    end
    return r;
  endfunction

  // ----------------------------------------
  // Context selection
  // ----------------------------------------
  // Field for priority p sits at bits [3p-1:3p-3]; zero means no binding
  function automatic cpm_ctx_t ipl_context_assign_field(input logic [31:0] cfg,
                                                         input logic [2:0] interrupt_priority_level);
    cpm_ctx_t f;
    f = 3'h0;
    if (interrupt_priority_level != 3'h0) f = cfg[(interrupt_priority_level-1)*CTX_W +: CTX_W];
    if (f >= 3'(NUM_CTX)) f = 3'h0;
    return f;
  endfunction

  logic     swap_ev, irq_ev, reti_ev;
  cpm_ctx_t irq_ctx;
  assign swap_ev = exec_in.op == CPM_OP_SWAP;
  assign irq_ev  = exec_in.op == CPM_OP_IRQ;
  assign reti_ev = exec_in.op == CPM_OP_RETI;
  assign irq_ctx = ipl_context_assign_field(alt_register_config_word, exec_in.arg);
  logic     sw_swap;
  assign sw_swap = wr_acc && paddr == CTXSWP_OFF && pstrb[0];

  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      cctx_ff <= 3'h0;
      mctx_ff <= 3'h0;
      nest_ff <= 3'h0;
      for (int i = 0; i < 8; i++) ret_ctx_ff[i] <= 3'h0;
    end else if (clk_en) begin
      if (irq_ev) begin
        ret_ctx_ff[nest_ff] <= cctx_ff;
        nest_ff             <= nest_ff + 3'h1;
        if (irq_ctx != 3'h0) cctx_ff <= irq_ctx;
      end else if (reti_ev && nest_ff != 3'h0) begin
        cctx_ff <= ret_ctx_ff[nest_ff - 3'h1];
        nest_ff <= nest_ff - 3'h1;
      end else if (swap_ev && exec_in.arg < 3'(NUM_CTX)) begin
        cctx_ff <= exec_in.arg;
        mctx_ff <= exec_in.arg;
      end else if (sw_swap && pwdata[2:0] < 3'(NUM_CTX)) begin
        cctx_ff <= pwdata[2:0];
        mctx_ff <= pwdata[2:0];
      end
    end
  end

  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) alt_register_config_word <= ALTCFG_RST;
    else if (wr_acc && paddr == ALTCFG_OFF)
      alt_register_config_word <= merge(alt_register_config_word, pwdata, pstrb);
  end

  // ----------------------------------------
  // Working registers and stack pointer
  // ----------------------------------------
  logic [31:0] wcur, wmrg;
  assign wcur = (widx == 4'hf) ? {16'h0, sp_ff} : {16'h0, wreg_ff[cctx_ff][widx]};
  assign wmrg = merge(wcur, pwdata, pstrb);
  // Execution-unit writes win over a bus write in the same cycle
  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      for (int c = 0; c < NUM_CTX; c++)
        for (int r = 0; r < NUM_WREG-1; r++) wreg_ff[c][r] <= 16'h0000;
      sp_ff <= SP_RST;
    end else if (clk_en) begin
      if (exec_in.wr_en) begin
        if (exec_in.wr_idx == 4'hf) sp_ff <= exec_in.wr_data;
        else wreg_ff[cctx_ff][exec_in.wr_idx] <= exec_in.wr_data;
      end else if (wr_acc && hit_wreg) begin
        if (widx == 4'hf) sp_ff <= wmrg[15:0];
        else wreg_ff[cctx_ff][widx] <= wmrg[15:0];
      end
    end
  end
  assign stack_pointer_register = sp_ff;
  assign current_context_index  = cctx_ff;

  // ----------------------------------------
  // Accumulators, one pair per context
  // ----------------------------------------
  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      for (int c = 0; c < NUM_CTX; c++) begin
        accumulator_a_ff[c] <= 40'h0;
        accumulator_b_ff[c] <= 40'h0;
      end
    end else if (wr_acc) begin
      unique case (paddr)
        ACCUMULATOR_A_LO: accumulator_a_ff[cctx_ff][31:0]  <= merge(accumulator_a_ff[cctx_ff][31:0], pwdata, pstrb);
        ACCUMULATOR_A_HI: if (pstrb[0]) accumulator_a_ff[cctx_ff][39:32] <= pwdata[7:0];
        ACCUMULATOR_B_LO: accumulator_b_ff[cctx_ff][31:0]  <= merge(accumulator_b_ff[cctx_ff][31:0], pwdata, pstrb);
        ACCUMULATOR_B_HI: if (pstrb[0]) accumulator_b_ff[cctx_ff][39:32] <= pwdata[7:0];
        default: ;
      endcase
    end
  end

  // ----------------------------------------
  // Program counter, loop start, issue timing
  // ----------------------------------------
  // Long instructions hold issue for one extra cycle; an interrupt
  // may still land at any cycle, loops included
  logic long_insn;
  assign long_insn = insn_word[23:20] == 4'h0 || insn_word[23:19] == 5'h1f;

  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      pc_ff     <= '0;
      lstart_ff <= '0;
      wait_ff   <= 2'h0;
      group_ff  <= 4'h0;
    end else if (clk_en) begin
      if (loop_start_load) lstart_ff <= pc_ff;
      if (pc_load || irq_ev) begin
        pc_ff   <= pc_target;
        wait_ff <= 2'(PENDING_CYC);
      end else if (wr_acc && paddr == PC_OFF) begin
        pc_ff <= pwdata[PC_W-1:0];
      end else if (wait_ff != 2'h0) begin
        wait_ff <= wait_ff - 2'h1;
      end else if (pc_step) begin
        pc_ff <= pc_ff + 23'h2;
        if (long_insn) wait_ff <= 2'(PENDING_CYC - 1);
        // Opcode length varies; the group is in the leading bits
        group_ff <= insn_word[23] ? insn_word[22:19] : {1'b0, insn_word[22:20]};
      end
    end
  end
  assign pc_out         = pc_ff;
  assign busy_out       = wait_ff != 2'h0;
  // Group code names one of six addressing modes or fewer
  assign insn_group_out = (group_ff > 4'h5) ? 4'h5 : group_ff;

  // ----------------------------------------
  // Address generators
  // ----------------------------------------
  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      agcfg_ff <= 32'h0;
      xms_ff <= 16'h0; xme_ff <= 16'h0; yms_ff <= 16'h0; yme_ff <= 16'h0;
      brev_ff <= 16'h0;
    end else if (wr_acc) begin
      unique case (paddr)
        AGCFG_OFF:  agcfg_ff <= merge(agcfg_ff, pwdata, pstrb);
        XMOD_START: xms_ff   <= pwdata[15:0];
        XMOD_END:   xme_ff   <= pwdata[15:0];
        YMOD_START: yms_ff   <= pwdata[15:0];
        YMOD_END:   yme_ff   <= pwdata[15:0];
        BREV_OFF:   brev_ff  <= pwdata[15:0];
        default: ;
      endcase
    end
  end

  function automatic cpm_word_t modwrap(input cpm_word_t a, input cpm_word_t s,
                                        input cpm_word_t e);
    cpm_word_t r;
    r = a;
    if (a > e) r = s + (a - e - 16'h1);
    else if (a < s) r = e - (s - a - 16'h1);
    return r;
  endfunction

  function automatic cpm_word_t bitrev(input cpm_word_t a, input cpm_word_t mod);
    cpm_word_t ra, rm, s, r;
    ra = {<<{a}};
    rm = {<<{mod}};
    // Reverse-carry add over the buffer size bits
    s  = ra + rm;
    r  = {<<{s}};
    return r;
  endfunction

  // Request written by software: [15:0] X address, [31:16] Y address
  logic agreq_wr;
  cpm_word_t xa, ya, xn, yn;
  logic dual;
  assign agreq_wr = wr_acc && paddr == AGREQ_OFF;
  assign xa = pwdata[15:0];
  assign ya = pwdata[31:16];
  assign dual = agcfg_ff[AG_YMOD_BIT] || pstrb[3];

  always_comb begin
    xn = xa;
    if (agcfg_ff[AG_BREV_BIT]) xn = bitrev(xa, brev_ff);
    else if (agcfg_ff[AG_XMOD_BIT]) xn = modwrap(xa, xms_ff, xme_ff);
    yn = ya;
    if (agcfg_ff[AG_YMOD_BIT]) yn = modwrap(ya, yms_ff, yme_ff);
    if (dual) begin
      if (xn >= 16'(XY_SPLIT)) xn = xn - 16'(XY_SPLIT);
      yn = 16'(XY_SPLIT) + yn;
    end
  end

  logic                 done_ff;
  logic [PC_W-1:0]      pma_ff;
  logic                 pmv_ff;
  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      xres_ff <= 16'h0; yres_ff <= 16'h0; done_ff <= 1'b0;
      pma_ff <= '0; pmv_ff <= 1'b0;
    end else if (clk_en) begin
      done_ff <= agreq_wr;
      if (agreq_wr) begin
        xres_ff <= xn;
        yres_ff <= yn;
        // Upper half of data space reads program memory when windowed
        pmv_ff <= agcfg_ff[AG_PSV_BIT] && xn >= PSV_WIN_BASE;
        pma_ff <= {agcfg_ff[AG_PAGE_LSB +: PSV_PAGE_W], xn[14:0]};
      end
    end
  end
  assign ag_done       = done_ff;
  assign pmem_valid    = pmv_ff;
  assign pmem_addr_out = pma_ff;

  // ----------------------------------------
  // Read mux
  // ----------------------------------------
  always_comb begin
    prdata = 32'h0;
    if (rd_acc) begin
      if (hit_wreg) prdata = wcur;
      else begin
        unique case (paddr)
          ACCUMULATOR_A_LO:     prdata = accumulator_a_ff[cctx_ff][31:0];
          ACCUMULATOR_A_HI:     prdata = {24'h0, accumulator_a_ff[cctx_ff][39:32]};
          ACCUMULATOR_B_LO:     prdata = accumulator_b_ff[cctx_ff][31:0];
          ACCUMULATOR_B_HI:     prdata = {24'h0, accumulator_b_ff[cctx_ff][39:32]};
          PC_OFF:      prdata = {9'h0, pc_ff};
          LSTART_L:    prdata = {16'h0, lstart_ff[15:0]};
          LSTART_H:    prdata = {25'h0, lstart_ff[22:16]};
          ALTCFG_OFF:  prdata = alt_register_config_word;
          CTXSTAT_OFF: prdata = {21'h0, mctx_ff, 5'h0, cctx_ff};
          AGCFG_OFF:   prdata = agcfg_ff;
          XMOD_START:  prdata = {16'h0, xms_ff};
          XMOD_END:    prdata = {16'h0, xme_ff};
          YMOD_START:  prdata = {16'h0, yms_ff};
          YMOD_END:    prdata = {16'h0, yme_ff};
          BREV_OFF:    prdata = {16'h0, brev_ff};
          AGRES_OFF:   prdata = {yres_ff, xres_ff};
          default:     prdata = 32'h0;
        endcase
      end
    end
  end
endmodule // cpm_regfile

// ===== verification/cpm_regfile_chk.sv
// Port checker for the register file
`timescale 1ns/100ps
module cpm_regfile_chk
  import cpm_pkg::*;
#(
  parameter int unsigned XY_SPLIT = 16'h0800
) (
  input wire logic                     pclk,
  input wire logic                     presetn,
  input wire logic                     clk_en,
  input wire logic                     psel,
  input wire logic                     penable,
  input wire logic                     pwrite,
  input wire logic [11:0]              paddr,
  input wire logic                     pready,
  input wire logic                     pslverr,
  input wire cpm_pkg::cpm_exec_t       exec_in,
  input wire logic                     pc_load,
  input wire logic [cpm_pkg::PC_W-1:0] pc_target,
  input wire logic [cpm_pkg::PC_W-1:0] pc_out,
  input wire logic [3:0]               insn_group_out,
  input wire cpm_pkg::cpm_ctx_t        current_context_index,
  input wire cpm_pkg::cpm_word_t       stack_pointer_register,
  input wire logic                     ag_done
);
  // ----------
  // Properties
  // ----------
  default clocking cb @(posedge pclk); endclocking
  default disable iff (!presetn);
  logic acc;
  logic lsa;
  assign acc = psel && penable;
  assign lsa = (paddr == LSTART_L) || (paddr == LSTART_H);
  property p_ready; acc |-> pready; endproperty
  a_ready: assert property (p_ready) else $error("pready low in access");
  property p_ro_wr; acc && pwrite && lsa |-> pslverr; endproperty
  a_ro_wr: assert property (p_ro_wr) else $error("loop start write accepted");
  property p_ro_rd; acc && !pwrite && lsa |-> !pslverr; endproperty
  a_ro_rd: assert property (p_ro_rd) else $error("loop start read refused");
  property p_unmap; acc && (paddr > AGRES_OFF) |-> pslverr; endproperty
  a_unmap: assert property (p_unmap) else $error("unmapped access accepted");
  property p_sp_rst; $rose(presetn) |-> stack_pointer_register == SP_RST; endproperty
  a_sp_rst: assert property (p_sp_rst) else $error("stack pointer reset value");
  property p_ctx_max; current_context_index <= 3'h4; endproperty
  a_ctx_max: assert property (p_ctx_max) else $error("context index out of range");
  // A swap op with arg 0-4 wins over a bus swap in the same cycle
  property p_swap;
    clk_en && exec_in.op == CPM_OP_SWAP && exec_in.arg <= 3'h4
      |=> current_context_index == $past(exec_in.arg);
  endproperty
  a_swap: assert property (p_swap) else $error("swap op not applied");
  property p_sp_wr;
    clk_en && exec_in.wr_en && exec_in.wr_idx == 4'hf
      |=> stack_pointer_register == $past(exec_in.wr_data);
  endproperty
  a_sp_wr: assert property (p_sp_wr) else $error("stack pointer write lost");
  property p_pc; clk_en && pc_load |=> pc_out == $past(pc_target); endproperty
  a_pc: assert property (p_pc) else $error("program counter load lost");
  property p_freeze; !clk_en |=> $stable(pc_out) && $stable(current_context_index); endproperty
  a_freeze: assert property (p_freeze) else $error("state moved while frozen");
  property p_group; insn_group_out <= 4'h5; endproperty
  a_group: assert property (p_group) else $error("more than six mode groups");
  property p_ag;
    clk_en && acc && pwrite && paddr == AGREQ_OFF |=> ag_done ##1 !ag_done;
  endproperty
  a_ag: assert property (p_ag) else $error("address result pulse wrong");
endmodule // cpm_regfile_chk

bind cpm_regfile cpm_regfile_chk #(.XY_SPLIT(XY_SPLIT)) i_cpm_regfile_chk (
  .pclk, .presetn, .clk_en, .psel, .penable, .pwrite, .paddr, .pready, .pslverr,
  .exec_in, .pc_load, .pc_target, .pc_out, .insn_group_out, .current_context_index,
  .stack_pointer_register, .ag_done);

// ===== verification/cpm_exec_model.sv
// Execution-unit model driving the core-side inputs
`timescale 1ns/100ps
module cpm_exec_model
  import cpm_pkg::*;
(
  input  wire logic                       pclk,
  output cpm_pkg::cpm_exec_t              exec_in,
  output logic                            pc_load,
  output logic [cpm_pkg::PC_W-1:0]        pc_target,
  output logic                            pc_step,
  output logic [cpm_pkg::INSN_W-1:0]      insn_word,
  output logic                            loop_start_load
);
  // ----------
  // Drivers
  // ----------
  initial begin
    exec_in = '0;
    pc_load = 1'b0;
    pc_target = '0;
    pc_step = 1'b0;
    insn_word = '0;
    loop_start_load = 1'b0;
  end
  // One-cycle pulse, cleared so an op never repeats
  task automatic issue(input cpm_op_t op, input logic [2:0] arg, input logic we,
                       input logic [3:0] idx, input cpm_word_t d);
    @(posedge pclk);
    exec_in <= '{op: op, arg: arg, wr_en: we, wr_idx: idx, wr_data: d};
    @(posedge pclk);
    exec_in <= '0;
  endtask
  task automatic jump(input logic [PC_W-1:0] t);
    @(posedge pclk);
    pc_load <= 1'b1;
    pc_target <= t;
    @(posedge pclk);
    pc_load <= 1'b0;
  endtask
  task automatic run(input logic [INSN_W-1:0] w);
    @(posedge pclk);
    pc_step <= 1'b1;
    insn_word <= w;
    loop_start_load <= 1'b1;
    @(posedge pclk);
    pc_step <= 1'b0;
    loop_start_load <= 1'b0;
  endtask
endmodule // cpm_exec_model

// ===== verification/testbench.sv
// Self-checking testbench for the register file
`timescale 1ns/100ps
module testbench;
  import cpm_pkg::*;
  logic               pclk, presetn, clk_en, psel, penable, pwrite, pready, pslverr;
  logic [11:0]        paddr;
  logic [31:0]        pwdata, prdata;
  logic [3:0]         pstrb, insn_group_out;
  logic               pc_load, pc_step, loop_start_load, pmem_valid, busy_out, ag_done;
  cpm_exec_t          exec_in;
  logic [PC_W-1:0]    pc_target, pc_out, pmem_addr_out;
  logic [INSN_W-1:0]  insn_word;
  cpm_ctx_t           current_context_index;
  cpm_word_t          stack_pointer_register;
  int                 err_count, checks_done;
  cpm_regfile #(.XY_SPLIT(16'h0800)) i_cpm_regfile (.pclk, .presetn, .clk_en, .psel,
    .penable, .pwrite, .paddr, .pwdata, .pstrb, .prdata, .pready, .pslverr, .exec_in,
    .pc_load, .pc_target, .pc_step, .insn_word, .loop_start_load, .pc_out, .pmem_valid,
    .busy_out, .insn_group_out, .current_context_index, .stack_pointer_register,
    .pmem_addr_out, .ag_done);
  cpm_exec_model i_cpm_exec_model (.pclk, .exec_in, .pc_load, .pc_target, .pc_step,
    .insn_word, .loop_start_load);
  initial begin
    pclk = 1'b0;
    forever #2 pclk = ~pclk;
  end
  // ----------
  // Helpers
  // ----------
  task automatic finish_test();
    $display("checks %0d mismatches %0d", checks_done, err_count);
    if (err_count == 0 && checks_done > 0) begin
      $display("*** PASS ***");
    end else begin
      $display("*** FAIL ***");
    end
    $finish;
  endtask
  task automatic chk(input string nm, input logic [31:0] e, input logic [31:0] g);
    checks_done++;
    if (g !== e) begin
      $display("[FAIL] %s expected %h seen %h", nm, e, g);
      err_count++;
    end
  endtask
  // For reads d is the expected data
  task automatic xfer(input logic w, input logic [11:0] a, input logic [31:0] d,
                      input logic e_err, input string nm);
    int n;
    logic [31:0] rd;
    logic err;
    n = 0;
    @(posedge pclk);
    psel <= 1'b1;
    penable <= 1'b0;
    pwrite <= w;
    paddr <= a;
    pwdata <= w ? d : 32'h0;
    @(posedge pclk);
    penable <= 1'b1;
    do begin
      @(posedge pclk);
      n++;
    end while (pready !== 1'b1 && n < 20);
    rd = prdata;
    err = pslverr;
    psel <= 1'b0;
    penable <= 1'b0;
    if (n >= 20) begin
      err_count++;
      finish_test();
    end else begin
      chk({nm, "_err"}, {31'h0, e_err}, {31'h0, err});
      if (!w && !e_err) chk(nm, d, rd);
    end
  endtask
  task automatic ctx_op(input cpm_op_t op, input logic [2:0] arg, input logic [2:0] e);
    i_cpm_exec_model.issue(op, arg, 1'b0, 4'h0, 16'h0);
    #1;
    chk("ctx", {29'h0, e}, {29'h0, current_context_index});
  endtask
  // ----------
  // Scenarios
  // ----------
  task automatic t_regs();
    xfer(1'b0, 12'h03c, {16'h0, SP_RST}, 1'b0, "sp_rst");
    xfer(1'b0, ALTCFG_OFF, ALTCFG_RST, 1'b0, "alt_rst");
    for (int i = 0; i < 16; i++) xfer(1'b1, 12'(4 * i), 32'ha500 + i, 1'b0, "w");
    for (int i = 0; i < 16; i++) xfer(1'b0, 12'(4 * i), 32'ha500 + i, 1'b0, "w");
    $display("test regs done");
  endtask
  task automatic t_ctx();
    xfer(1'b1, CTXSWP_OFF, 32'h2, 1'b0, "swap");
    xfer(1'b0, CTXSTAT_OFF, 32'h0202, 1'b0, "stat");
    xfer(1'b0, WREG_BASE, 32'h0, 1'b0, "w0_alt");
    xfer(1'b0, 12'h03c, 32'ha50f, 1'b0, "sp_shared");
    xfer(1'b1, WREG_BASE, 32'hbeef, 1'b0, "w0_alt");
    ctx_op(CPM_OP_SWAP, 3'h0, 3'h0);
    xfer(1'b0, WREG_BASE, 32'ha500, 1'b0, "w0_main");
    ctx_op(CPM_OP_SWAP, 3'h7, 3'h0);
    ctx_op(CPM_OP_SWAP, 3'h2, 3'h2);
    xfer(1'b0, WREG_BASE, 32'hbeef, 1'b0, "w0_kept");
    ctx_op(CPM_OP_SWAP, 3'h0, 3'h0);
    $display("test ctx done");
  endtask
  task automatic t_irq();
    xfer(1'b1, ALTCFG_OFF, 32'h0010_3001, 1'b0, "alt");
    xfer(1'b0, ALTCFG_OFF, 32'h0010_3001, 1'b0, "alt");
    ctx_op(CPM_OP_IRQ, 3'h5, 3'h3);
    xfer(1'b0, CTXSTAT_OFF, 32'h0003, 1'b0, "stat_irq");
    ctx_op(CPM_OP_IRQ, 3'h7, 3'h4);
    ctx_op(CPM_OP_IRQ, 3'h2, 3'h4);
    ctx_op(CPM_OP_RETI, 3'h0, 3'h4);
    ctx_op(CPM_OP_RETI, 3'h0, 3'h3);
    ctx_op(CPM_OP_RETI, 3'h0, 3'h0);
    ctx_op(CPM_OP_IRQ, 3'h1, 3'h1);
    ctx_op(CPM_OP_RETI, 3'h0, 3'h0);
    i_cpm_exec_model.issue(CPM_OP_NONE, 3'h0, 1'b1, 4'hf, 16'h1234);
    xfer(1'b0, 12'h03c, 32'h1234, 1'b0, "sp_exec");
    $display("test irq done");
  endtask
  task automatic t_map();
    xfer(1'b1, LSTART_L, 32'h1234, 1'b1, "ls_lo");
    xfer(1'b0, LSTART_L, 32'h0, 1'b0, "ls_lo");
    xfer(1'b1, LSTART_H, 32'h1234, 1'b1, "ls_hi");
    xfer(1'b0, LSTART_H, 32'h0, 1'b0, "ls_hi");
    xfer(1'b1, 12'hffc, 32'h1, 1'b1, "unmap");
    xfer(1'b0, 12'hffc, 32'h0, 1'b1, "unmap");
    xfer(1'b1, ACCUMULATOR_A_LO, 32'h89ab_cdef, 1'b0, "accumulator_a");
    xfer(1'b1, ACCUMULATOR_A_HI, 32'hffff_ffff, 1'b0, "accumulator_a_hi");
    xfer(1'b0, ACCUMULATOR_A_HI, 32'h0000_00ff, 1'b0, "accumulator_a_hi");
    xfer(1'b1, CTXSWP_OFF, 32'h1, 1'b0, "swap");
    xfer(1'b0, ACCUMULATOR_A_LO, 32'h0, 1'b0, "accumulator_a_alt");
    xfer(1'b1, CTXSWP_OFF, 32'h0, 1'b0, "swap");
    xfer(1'b0, ACCUMULATOR_A_LO, 32'h89ab_cdef, 1'b0, "accumulator_a");
    $display("test map done");
  endtask
  task automatic t_core();
    logic [23:0] words [4] = '{24'h00_0000, 24'hff_ffff, 24'h78_0f20, 24'h06_0000};
    i_cpm_exec_model.jump(23'h7f_ffff);
    #1;
    chk("pc", 32'h007f_ffff, {9'h0, pc_out});
    xfer(1'b0, PC_OFF, 32'h007f_ffff, 1'b0, "pc_reg");
    foreach (words[i]) i_cpm_exec_model.run(words[i]);
    #1;
    chk("busy", 32'h1, {31'h0, busy_out});
    xfer(1'b0, PC_OFF, 32'h0000_0007, 1'b0, "pc_step");
    pstrb <= 4'h7;
    xfer(1'b1, AGCFG_OFF, 32'h0000_0208, 1'b0, "agcfg");
    xfer(1'b1, AGREQ_OFF, 32'h0000_8004, 1'b0, "agreq");
    @(posedge pclk);
    #1;
    chk("win_hit", 32'h1, {31'h0, pmem_valid});
    chk("win_addr", 32'h0001_0004, {9'h0, pmem_addr_out});
    xfer(1'b1, AGREQ_OFF, 32'h0000_0004, 1'b0, "agreq");
    @(posedge pclk);
    #1;
    chk("win_miss", 32'h0, {31'h0, pmem_valid});
    pstrb <= 4'hf;
    xfer(1'b1, AGCFG_OFF, 32'h0000_0007, 1'b0, "agcfg");
    xfer(1'b1, AGREQ_OFF, 32'h0000_0010, 1'b0, "agreq");
    xfer(1'b0, AGRES_OFF, 32'h0800_0010, 1'b0, "agres");
    $display("test core done");
  endtask
  task automatic t_misc();
    clk_en <= 1'b0;
    xfer(1'b1, 12'h004, 32'h1111, 1'b0, "frozen");
    clk_en <= 1'b1;
    xfer(1'b0, 12'h004, 32'ha501, 1'b0, "w1_kept");
    presetn <= 1'b0;
    repeat (2) @(posedge pclk);
    presetn <= 1'b1;
    @(posedge pclk);
    xfer(1'b0, 12'h03c, {16'h0, SP_RST}, 1'b0, "sp_rst2");
    xfer(1'b0, CTXSTAT_OFF, 32'h0, 1'b0, "stat_rst");
    $display("test misc done");
  endtask
  initial begin
    err_count = 0;
    checks_done = 0;
    presetn = 1'b0;
    clk_en = 1'b1;
    psel = 1'b0;
    penable = 1'b0;
    pwrite = 1'b0;
    paddr = 12'h000;
    pwdata = 32'h0;
    pstrb = 4'hf;
    repeat (12) @(posedge pclk);
    presetn <= 1'b1;
    @(posedge pclk);
    t_regs();
    t_ctx();
    t_irq();
    t_map();
    t_core();
    t_misc();
    finish_test();
  end
endmodule // testbench
